// ---- rtl/eeprom_pkg.sv ----
/*
  Types of the serial EEPROM slave: the bus state machine encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Bus states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CTRL  = 6'h02,
    ST_ADRH  = 6'h04,
    ST_ADRL  = 6'h08,
    ST_WDATA = 6'h10,
    ST_RDATA = 6'h20
  } bus_state_t;

endpackage : eeprom_pkg

// ---- rtl/eeprom_regs.svh ----
/*
  Constants of the serial EEPROM slave: widths, filter length, buffer depth, timing.
  Assumes it is included by bare name from the design file and the bench.
*/
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define EE_ADDR_W      12
`define EE_DATA_W      8
`define EE_PAGE_BITS   5
`define EE_ADDR_HI_W   4
`define EE_FIFO_W      20
`define EE_FIFO_DEPTH  32

// ----------------------------------------------------------------
// Control byte
// ----------------------------------------------------------------
// Device-type code: value is arbitrary
`define EE_DEV_TYPE    4'h5
`define EE_BITS_BYTE   4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EE_FILT_LEN    2
`define EE_PROG_CYCLES 5000
`define EE_SYNC_RST    7'h03

`endif

// ---- rtl/eeprom_seq_read.sv ----
/*
  Two-wire slave of a 4K x 8 serial EEPROM: addressing, sequential read, page buffer,
  write protect, input filtering and standby.
  Assumes every pin input is asynchronous to ref_clk_i and SDA has an external pull-up.
*/
// Operation
// - Each byte the controller acknowledges is followed by the next array byte.
// - Internal word pointer advances by one per completed byte.
// - Pointer wraps from the top address to zero and reading continues.
// - Only a control byte whose select bits equal the straps is answered.
// - SDA is only pulled low or released, never driven high.
// - SDA changes only while SCL is low; high-phase changes mean START/STOP.
// - Write protect low allows reads and writes over the whole array.
// - Write protect high blocks every array write; reads are unaffected.
// - SCL and SDA are filtered so short spikes are ignored.
// - Standby is entered after STOP and internal work, also after errors.
// - Array writes are suppressed on low supply; monitor off in standby.
// - First byte after START is type code, select bits, direction bit.
// - Repeated START ends a write's data phase but keeps the loaded pointer and the buffered bytes, which are programmed at STOP.
// - No acknowledge at all while a programming cycle runs.
`timescale 1ns/1ps
`include "eeprom_regs.svh"

module eeprom_seq_read #(
  parameter int PROG_CYCLES = `EE_PROG_CYCLES,
  parameter int FIFO_DEPTH  = `EE_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  // Two-wire bus
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Straps and protection
  input  wire logic [2:0] chip_select_straps_i,
  input  wire logic       wp_i,
  input  wire logic       low_vdd_i,
  // Status
  output logic            standby_o,
  output logic            vdd_mon_en_o,
  output logic            prog_busy_o
);

  localparam int FL = `EE_FILT_LEN;

  logic [6:0]                  meta_r;
  logic [6:0]                  sync_r;
  logic [FL-1:0]               hist_r [2];
  logic [1:0]                  filt_r;
  logic [1:0]                  filt_d_r;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_det;
  logic                        stop_det;
  logic                        sda_s;
  logic                        wp_s;
  logic                        low_vdd_s;
  logic [2:0]                  straps_s;

  eeprom_pkg::bus_state_t      state_r;
  logic [3:0]                  bitcnt_r;
  logic                        ack_ph_r;
  logic [`EE_DATA_W-1:0]       shift_r;
  logic                        oe_r;
  logic                        mack_r;
  logic [`EE_ADDR_W-1:0]       ptr_r;
  logic [`EE_ADDR_HI_W-1:0]    adr_hi_r;
  logic                        pend_r;
  logic                        match;
  logic                        ack_ok;
  logic                        byte_end;
  logic                        prog_start;

  logic [`EE_DATA_W-1:0]       mem_r [2**`EE_ADDR_W];
  logic                        busy_r;
  logic [31:0]                 tmr_r;
  logic                        standby_r;
  logic                        fifo_in_valid;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic [`EE_FIFO_W-1:0]       fifo_out_data;
  logic                        wr_allow;

  // ----------------------------------------------------------------
  // Pin synchronisers and spike filter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      meta_r <= `EE_SYNC_RST;
      sync_r <= `EE_SYNC_RST;
    end else begin
      meta_r <= {chip_select_straps_i, low_vdd_i, wp_i, sda_i, scl_i};
      sync_r <= meta_r;
    end
  end

  // Level changes only after FL+1 agreeing samples; adds FL cycles of latency
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hist_r[0] <= '1;
      hist_r[1] <= '1;
      filt_r    <= 2'h3;
      filt_d_r  <= 2'h3;
    end else begin
      for (int i = 0; i < 2; i++) begin
        hist_r[i] <= {hist_r[i][FL-2:0], sync_r[i]};
        if (&{hist_r[i], sync_r[i]}) begin
          filt_r[i] <= 1'b1;
        end else if (~|{hist_r[i], sync_r[i]}) begin
          filt_r[i] <= 1'b0;
        end
      end
      filt_d_r <= filt_r;
    end
  end

  assign sda_s     = filt_r[1];
  assign wp_s      = sync_r[2];
  assign low_vdd_s = sync_r[3];
  assign straps_s  = sync_r[6:4];
  assign scl_rise  = filt_r[0] & ~filt_d_r[0];
  // Fall taken as the filter commits, so the answer lands before SCL rises again
  assign scl_fall  = filt_r[0] & ~|{hist_r[0], sync_r[0]};
  assign start_det = filt_r[0] & filt_d_r[0] & filt_d_r[1] & ~filt_r[1];
  assign stop_det  = filt_r[0] & filt_d_r[0] & ~filt_d_r[1] & filt_r[1];

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  assign match = (shift_r[7:4] == `EE_DEV_TYPE) && (shift_r[3:1] == straps_s);
  assign ack_ok = match & ~busy_r;
  assign byte_end = scl_fall & ack_ph_r;
  assign fifo_in_valid = byte_end & (state_r == eeprom_pkg::ST_WDATA) & ~wp_s;
  assign prog_start = stop_det & pend_r;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_r  <= eeprom_pkg::ST_IDLE;
      bitcnt_r <= 4'h0;
      ack_ph_r <= 1'b0;
      shift_r  <= 8'h00;
      oe_r     <= 1'b0;
      mack_r   <= 1'b0;
      ptr_r    <= 12'h000;
      adr_hi_r <= 4'h0;
      pend_r   <= 1'b0;
    end else if (start_det) begin
      // Repeated start keeps ptr_r loaded
      state_r  <= eeprom_pkg::ST_CTRL;
      bitcnt_r <= 4'h0;
      ack_ph_r <= 1'b0;
      oe_r     <= 1'b0;
    end else if (stop_det) begin
      state_r  <= eeprom_pkg::ST_IDLE;
      ack_ph_r <= 1'b0;
      oe_r     <= 1'b0;
      pend_r   <= 1'b0;
    end else if (state_r != eeprom_pkg::ST_IDLE) begin
      if (scl_rise && !ack_ph_r) begin
        bitcnt_r <= bitcnt_r + 4'h1;
        if (state_r != eeprom_pkg::ST_RDATA) begin
          shift_r <= {shift_r[6:0], sda_s};
        end
      end else if (scl_rise && state_r == eeprom_pkg::ST_RDATA) begin
        mack_r <= ~sda_s;
      end else if (scl_fall && !ack_ph_r && bitcnt_r == `EE_BITS_BYTE) begin
        ack_ph_r <= 1'b1;
        unique case (state_r)
          eeprom_pkg::ST_CTRL:  oe_r <= ack_ok;
          eeprom_pkg::ST_RDATA: oe_r <= 1'b0;
          eeprom_pkg::ST_ADRH,
          eeprom_pkg::ST_ADRL,
          eeprom_pkg::ST_WDATA: oe_r <= 1'b1;
          eeprom_pkg::ST_IDLE:  oe_r <= 1'b0;
        endcase
      end else if (byte_end) begin
        ack_ph_r <= 1'b0;
        bitcnt_r <= 4'h0;
        oe_r     <= 1'b0;
        unique case (state_r)
          eeprom_pkg::ST_CTRL: begin
            if (!ack_ok) begin
              state_r <= eeprom_pkg::ST_IDLE;
            end else if (shift_r[0]) begin
              state_r <= eeprom_pkg::ST_RDATA;
              shift_r <= mem_r[ptr_r];
              oe_r    <= ~mem_r[ptr_r][7];
              ptr_r   <= ptr_r + 12'h001;
            end else begin
              state_r <= eeprom_pkg::ST_ADRH;
            end
          end
          eeprom_pkg::ST_ADRH: begin
            adr_hi_r <= shift_r[3:0];
            state_r  <= eeprom_pkg::ST_ADRL;
          end
          eeprom_pkg::ST_ADRL: begin
            ptr_r   <= {adr_hi_r, shift_r};
            state_r <= eeprom_pkg::ST_WDATA;
          end
          eeprom_pkg::ST_WDATA: begin
            // Page write: only the low bits advance
            ptr_r[4:0] <= ptr_r[4:0] + 5'h01;
            pend_r     <= pend_r | (fifo_in_valid & fifo_in_ready);
          end
          eeprom_pkg::ST_RDATA: begin
            if (mack_r) begin
              shift_r <= mem_r[ptr_r];
              oe_r    <= ~mem_r[ptr_r][7];
              ptr_r   <= ptr_r + 12'h001;
            end else begin
              // Missing acknowledge: line left high, wait for STOP
              state_r <= eeprom_pkg::ST_IDLE;
            end
          end
          eeprom_pkg::ST_IDLE: begin
          end
        endcase
      end else if (scl_fall && !ack_ph_r && state_r == eeprom_pkg::ST_RDATA && bitcnt_r != 4'h0) begin
        shift_r <= {shift_r[6:0], 1'b0};
        oe_r    <= ~shift_r[6];
      end
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_r;

  // ----------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------
  // Bytes beyond the buffer depth are dropped rather than overwriting
  sync_fifo #(
    .WIDTH (`EE_FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_page_buf (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({ptr_r, shift_r}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (busy_r),
    .out_data_o  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Programming cycle and array
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      busy_r <= 1'b0;
      tmr_r  <= 32'h0000_0000;
    end else if (prog_start) begin
      busy_r <= 1'b1;
      tmr_r  <= 32'h0000_0000;
    end else if (busy_r) begin
      if (tmr_r != 32'(PROG_CYCLES - 1)) begin
        tmr_r <= tmr_r + 32'h0000_0001;
      end else if (!fifo_out_valid) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Monitor only counts while awake
  assign wr_allow = ~wp_s & ~(low_vdd_s & vdd_mon_en_o);

  always_ff @(posedge ref_clk_i) begin
    if (busy_r && fifo_out_valid && wr_allow) begin
      mem_r[fifo_out_data[19:8]] <= fifo_out_data[7:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      standby_r <= 1'b1;
    end else begin
      standby_r <= (state_r == eeprom_pkg::ST_IDLE) & ~busy_r & ~prog_start;
    end
  end

  assign standby_o    = standby_r;
  assign vdd_mon_en_o = ~standby_r;
  assign prog_busy_o  = busy_r;

endmodule : eeprom_seq_read

// ---- rtl/sync_fifo.sv ----
/*
  Synchronous FIFO with valid/ready on both sides, used as the page buffer.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module sync_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = store_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      store_r[wr_ptr_r] <= in_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and fill level
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : sync_fifo

// ---- tb/bus_master.sv ----
/*
  Two-wire bus controller model: START, STOP, bytes, clock spike.
  Assumes SDA is resolved outside with a pull-up.
*/
`timescale 1ns/1ps

module bus_master (
  // Clock
  input  wire logic ref_clk_i,
  // Bus
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // --------------------
  // Bus tasks
  // --------------------
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : wt

  // Long low phase: the slave answers some cycles after the fall
  task automatic bit_xfer(input logic v, output logic s);
    wt(2);
    sda_low_o = !v;
    wt(3);
    scl_o = 1'b1;
    wt(2);
    s = sda_line_i;
    wt(1);
    scl_o = 1'b0;
  endtask : bit_xfer

  task automatic start();
    wt(2);
    sda_low_o = 1'b0;
    wt(3);
    scl_o = 1'b1;
    wt(3);
    sda_low_o = 1'b1;
    wt(3);
    scl_o = 1'b0;
  endtask : start

  task automatic stop();
    wt(2);
    sda_low_o = 1'b1;
    wt(3);
    scl_o = 1'b1;
    wt(3);
    sda_low_o = 1'b0;
    wt(8);
  endtask : stop

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], s);
    bit_xfer(1'b1, s);
    ack = !s;
  endtask : put_byte

  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(1'b1, b[i]);
    bit_xfer(!ack, s);
  endtask : get_byte

  task automatic spike();
    wt(2);
    scl_o = 1'b1;
    wt(1);
    scl_o = 1'b0;
  endtask : spike
endmodule : bus_master

// ---- tb/eeprom_seq_read_assertions.sv ----
/*
  Port checker of the serial EEPROM slave.
  Assumes it is bound to eeprom_seq_read.
*/
`timescale 1ns/1ps

module eeprom_chk #(
  parameter int PROG_CYCLES = 200,
  parameter int FIFO_DEPTH  = 32
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Bus and status
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic standby_o,
  input wire logic vdd_mon_en_o,
  input wire logic prog_busy_o
);
  // --------------------
  // Busy length counter
  // --------------------
  logic [15:0] busy_cnt_r;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !prog_busy_o)
      busy_cnt_r <= 16'h0000;
    else
      busy_cnt_r <= busy_cnt_r + 16'h0001;
  end

  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  a_open_drain: assert property (sda_o == 1'b0) else $error("sda driven high");
  a_monitor_standby: assert property (vdd_mon_en_o == !standby_o) else $error("monitor on in standby");
  a_busy_awake: assert property (prog_busy_o |-> !standby_o) else $error("standby while busy");
  a_standby_quiet: assert property (standby_o |-> !sda_oe_o) else $error("drive in standby");
  a_busy_no_ack: assert property (prog_busy_o |-> !sda_oe_o) else $error("ack while busy");
  a_reset_idle: assert property ($fell(srst_i) |-> standby_o && !sda_oe_o && !prog_busy_o)
    else $error("not idle after reset");
  a_drive_holds: assert property ($rose(sda_oe_o) |=> sda_oe_o[*6]) else $error("drive too short");
  a_release_holds: assert property ($fell(sda_oe_o) |=> !sda_oe_o[*6]) else $error("release too short");
  // Drain of a full page fits inside the programming time
  a_busy_length: assert property ($fell(prog_busy_o) |-> busy_cnt_r >= PROG_CYCLES - 1 &&
    busy_cnt_r <= PROG_CYCLES + 4) else $error("busy length off");
endmodule : eeprom_chk

bind eeprom_seq_read eeprom_chk #(.PROG_CYCLES(PROG_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .standby_o(standby_o), .vdd_mon_en_o(vdd_mon_en_o), .prog_busy_o(prog_busy_o));

// ---- tb/tb.sv ----
/*
  Self-checking bench of the EEPROM slave.
  Assumes bus_master on the far side and the bound checker.
*/
`timescale 1ns/1ps
`include "eeprom_regs.svh"

module tb;
  // --------------------
  // Harness
  // --------------------
  logic       ref_clk_i = 1'b0;
  logic       srst_i    = 1'b1;
  logic [2:0] straps    = 3'h5;
  logic       wp        = 1'b0;
  logic       low_vdd   = 1'b0;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       standby;
  logic       busy;
  int         fails           = 0;
  int         samples_checked = 0;
  wire        sda_line        = !(sda_oe | sda_low);

  always #50 ref_clk_i = ~ref_clk_i;

  eeprom_seq_read #(.PROG_CYCLES(200)) dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(),
    .sda_oe_o(sda_oe), .chip_select_straps_i(straps), .wp_i(wp), .low_vdd_i(low_vdd),
    .standby_o(standby), .vdd_mon_en_o(), .prog_busy_o(busy));

  bus_master bm (.ref_clk_i(ref_clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // --------------------
  // Transfers
  // --------------------
  task automatic sel(input logic rnw, input logic [2:0] s, input logic exp_ack);
    logic a;
    bm.start();
    bm.put_byte({`EE_DEV_TYPE, s, rnw}, a);
    check(a, exp_ack);
  endtask : sel

  task automatic set_ptr(input logic [11:0] a);
    logic k;
    sel(1'b0, straps, 1'b1);
    bm.put_byte({4'h0, a[11:8]}, k);
    check(k, 1'b1);
    bm.put_byte(a[7:0], k);
    check(k, 1'b1);
  endtask : set_ptr

  task automatic wr(input logic [11:0] a, input logic [15:0] d, input int n);
    logic k;
    set_ptr(a);
    for (int i = 0; i < n; i++) begin
      bm.put_byte(d[15-8*i -: 8], k);
      check(k, 1'b1);
    end
    bm.stop();
  endtask : wr

  task automatic settle();
    for (int c = 0; c < 400 && busy !== 1'b0; c++)
      @(negedge ref_clk_i);
    repeat (3) @(negedge ref_clk_i);
    check(standby, 1'b1);
  endtask : settle

  task automatic rd(input logic [11:0] a, input int n, input logic [23:0] exp);
    logic [7:0] b;
    set_ptr(a);
    sel(1'b1, straps, 1'b1);
    for (int i = 0; i < n; i++) begin
      bm.get_byte(i < n - 1, b);
      check(b, exp[23-8*i -: 8]);
    end
    bm.stop();
  endtask : rd

  // --------------------
  // Scenarios
  // --------------------
  task automatic sc_wrap();
    wr(12'hFFE, 16'hA53C, 2);
    settle();
    wr(12'h000, 16'h5A00, 1);
    settle();
    rd(12'hFFE, 3, 24'hA53C5A);
  endtask : sc_wrap

  task automatic sc_select();
    logic k;
    for (int s = 0; s < 8; s++) begin
      sel(1'b0, s[2:0], s[2:0] == straps);
      bm.stop();
    end
    bm.start();
    bm.put_byte({`EE_DEV_TYPE ^ 4'h1, straps, 1'b0}, k);
    check(k, 1'b0);
    bm.stop();
    straps = 3'h2;
    sel(1'b0, 3'h2, 1'b1);
    bm.stop();
    sel(1'b0, 3'h5, 1'b0);
    bm.stop();
    straps = 3'h5;
  endtask : sc_select

  // Controller polls right after the STOP that starts programming
  task automatic sc_busy();
    wr(12'h010, 16'h1200, 1);
    check(busy, 1'b1);
    sel(1'b0, straps, 1'b0);
    bm.stop();
    settle();
  endtask : sc_busy

  task automatic sc_protect();
    wp = 1'b1;
    wr(12'hFFE, 16'h7700, 1);
    settle();
    wp      = 1'b0;
    low_vdd = 1'b1;
    wr(12'hFFF, 16'h8800, 1);
    settle();
    low_vdd = 1'b0;
    rd(12'hFFE, 2, 24'hA53C00);
  endtask : sc_protect

  // Spike on the clock, then no acknowledge; idle is checked before the STOP
  task automatic sc_spike();
    logic [7:0] b;
    set_ptr(12'h000);
    sel(1'b1, straps, 1'b1);
    bm.spike();
    bm.get_byte(1'b0, b);
    check(b, 8'h5A);
    repeat (12) @(negedge ref_clk_i);
    check(sda_oe, 1'b0);
    check(standby, 1'b1);
    bm.stop();
  endtask : sc_spike

  initial begin
    repeat (4) @(negedge ref_clk_i);
    srst_i = 1'b0;
    repeat (10) @(negedge ref_clk_i);
    check(standby, 1'b1);
    sc_wrap();
    sc_select();
    sc_busy();
    sc_protect();
    sc_spike();
    summarize();
  end

  initial begin
    repeat (60000) @(negedge ref_clk_i);
    fails++;
    summarize();
  end
endmodule : tb
